// ===== src/fo_gpio_defs.vh
// Purpose: shared constants for the fail output and gpio pin control
// Assumes: 20 MHz system clock, 32-bit avalon-mm register bus
// Notes:   offsets are byte addresses of word-aligned registers
`ifndef FO_GPIO_DEFS_VH
`define FO_GPIO_DEFS_VH

// clock
`define CLK_PERIOD_NS        50

// timing, figures in ns and derived cycle counts (rounded down, never zero)
`define IRQ_PULSE_NS         100000
`define IRQ_GAP_NS           100000
`define WAKE_FILTER_NS       16000
`define WAKE_BLANK_NS        10000
`define IRQ_PULSE_CYC        (`IRQ_PULSE_NS / `CLK_PERIOD_NS)
`define IRQ_GAP_CYC          (`IRQ_GAP_NS / `CLK_PERIOD_NS)
`define WAKE_FILTER_CYC      (`WAKE_FILTER_NS / `CLK_PERIOD_NS)
`define WAKE_BLANK_CYC       (`WAKE_BLANK_NS / `CLK_PERIOD_NS)

// register byte offsets
`define OFS_PIN_CTRL         4'h0
`define OFS_DEV_STATUS       4'h4
`define OFS_WAKE_STATUS      4'h8
`define OFS_LEVEL_STATUS     4'hc

// pin control register fields
`define CTRL_FUNC_LSB        0
`define CTRL_TEST_BIT        3
`define CTRL_LOCK_BIT        4
`define CTRL_OV_RST_BIT      5
`define CTRL_MEAS_BIT        6
`define CTRL_PULL_LSB        7

// device status fields
`define STAT_FAILURE_BIT     0
`define STAT_WD_MISS_BIT     1
`define STAT_CFG_BIT         2
`define STAT_WD_CAUSE_BIT    3

// wake status fields
`define WK_PIN_EVENT_BIT     0
`define WK_PIN_OC_BIT        1

// pin function codes
`define FUNC_FAIL_MAX        3'h2
`define FUNC_OFF             3'h4
`define FUNC_WAKE            3'h5
`define FUNC_LOW_SIDE        3'h6
`define FUNC_RESET           3'h0

// operating mode codes on sys_mode
`define MODE_INIT            3'h0
`define MODE_NORMAL          3'h1
`define MODE_STOP            3'h2
`define MODE_SLEEP           3'h3
`define MODE_RESTART         3'h4
`define MODE_FAILSAFE        3'h5

`endif

// ===== src/pin_wake_filter.v
// Purpose: blanking and level filter for the pin when used as wake input
// Assumes: raw level synchronous to clk
// Notes:   reference starts low on enable; a change must hold a full filter time
`timescale 1ns/1ns
module pin_wake_filter #(
  parameter BLANK_CYC  = 200,
  parameter FILTER_CYC = 320,
  parameter CW         = 12
) (
  input  wire clk,
  input  wire rst_n,
  input  wire enable,
  input  wire raw,
  output reg  level_q,
  output reg  edge_q
);

  reg [CW-1:0] blank_q;
  reg [CW-1:0] filt_q;

  ////////////////////////////////////////////////////////////////////////////
  // blank after enable, then time out a stable changed level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_q <= {CW{1'b0}};
      filt_q  <= {CW{1'b0}};
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      edge_q <= 1'b0;
      if (!enable) begin
        blank_q <= {CW{1'b0}};
        filt_q  <= {CW{1'b0}};
        level_q <= 1'b0;                 // internal reference is low
      end else if (blank_q != BLANK_CYC[CW-1:0]) begin
        blank_q <= blank_q + {{(CW-1){1'b0}}, 1'b1};
      end else if (raw == level_q) begin
        filt_q <= {CW{1'b0}};
      end else if (filt_q == FILTER_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
        filt_q  <= {CW{1'b0}};
        level_q <= raw;
        edge_q  <= 1'b1;
      end else begin
        filt_q <= filt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pin_wake_filter

// ===== src/fail_output_and_gpio_control.v
// Purpose: fail output and general purpose control of the shared hv pin
// Assumes: avalon-mm slave with waitrequest, mode and failures given as inputs
// Notes:   pin is open drain, pin_oe high pulls it low
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`include "fo_gpio_defs.vh"
module fail_output_and_gpio_control #(
  parameter IRQ_PULSE_CYC = `IRQ_PULSE_CYC,
  parameter IRQ_GAP_CYC   = `IRQ_GAP_CYC,
  parameter WAKE_FILT_CYC = `WAKE_FILTER_CYC,
  parameter WAKE_BLNK_CYC = `WAKE_BLANK_CYC
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [2:0]  sys_mode,
  input  wire        thermal_shutdown_level_two,
  input  wire        main_short_to_gnd,
  input  wire        main_overvoltage,
  input  wire        wd_trigger_fail,
  input  wire        wd_trigger_ok,
  input  wire        wd_disabled,
  input  wire        pwm_on,
  input  wire        pin_overcurrent,
  input  wire        fail_signal_pin_in,
  input  wire        irq_line_in,
  output reg         fail_signal_pin_out,
  output reg         fail_signal_pin_oe,
  output reg         irq_line_n,
  output reg         failsafe_req,
  output reg         wake_req
);

  localparam [2:0] IRQ_IDLE  = 3'b001;
  localparam [2:0] IRQ_PULSE = 3'b010;
  localparam [2:0] IRQ_GAP   = 3'b100;

  reg        rst_meta_q;
  reg        rst_n_q;
  reg [2:0]  func_q;
  reg        test_q;
  reg        lock_q;
  reg        ov_en_q;
  reg        meas_q;
  reg [1:0]  pull_q;
  reg        failure_q;
  reg        wd_miss_q;
  reg        wd_cause_q;
  reg        two_strike_q;
  reg [1:0]  strikes_q;
  reg        fail_act_q;
  reg        wake_flag_q;
  reg        oc_flag_q;
  reg [2:0]  mode_q;
  reg [2:0]  irq_state_q;
  reg [11:0] irq_cnt_q;
  reg        irq_pend_q;

  wire        bus_go    = (avs_read | avs_write) & avs_waitrequest;
  // a write lands at the edge where the master sees waitrequest low
  wire        wr_go     = avs_write & ~avs_waitrequest;
  wire        wr_ctrl   = wr_go & (avs_address == `OFS_PIN_CTRL);
  wire        wr_dev    = wr_go & (avs_address == `OFS_DEV_STATUS);
  wire        wr_wake   = wr_go & (avs_address == `OFS_WAKE_STATUS);
  wire        mode_new  = (sys_mode != mode_q);
  wire        enter_rst = mode_new & (sys_mode == `MODE_RESTART);
  wire        enter_fs  = mode_new & (sys_mode == `MODE_FAILSAFE);
  wire        enter_slp = mode_new & (sys_mode == `MODE_SLEEP);
  wire        is_fail   = (func_q <= `FUNC_FAIL_MAX) & ~meas_q;
  wire        is_wake   = (func_q == `FUNC_WAKE) & ~meas_q;
  wire        is_ls     = (func_q == `FUNC_LOW_SIDE) & ~meas_q;
  wire        hard_fail;
  wire        wd_fire;
  wire        oc_trip;
  wire        wk_level;
  wire        wk_edge;

  // hard failure conditions, overvoltage only counts with its enable
  assign hard_fail = thermal_shutdown_level_two | main_short_to_gnd |
                     (main_overvoltage & ov_en_q);
  // watchdog miss reaches the fail output on the strike the config asks for
  assign wd_fire   = wd_trigger_fail & (~two_strike_q | (strikes_q != 2'h0));
  // overcurrent only judged during low-side on-time
  assign oc_trip   = is_ls & pwm_on & pin_overcurrent;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake input filter
  pin_wake_filter #(
    .BLANK_CYC  (WAKE_BLNK_CYC),
    .FILTER_CYC (WAKE_FILT_CYC),
    .CW         (12)
  ) u_wake_filter (
    .clk     (clk),
    .rst_n   (rst_n_q),
    .enable  (is_wake),
    .raw     (fail_signal_pin_in),
    .level_q (wk_level),
    .edge_q  (wk_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration sampled from the irq pin while in init
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      two_strike_q <= 1'b0;
      mode_q       <= `MODE_INIT;
    end else begin
      mode_q <= sys_mode;
      if (sys_mode == `MODE_INIT)
        two_strike_q <= irq_line_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin control register
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      func_q  <= `FUNC_RESET;
      test_q  <= 1'b0;
      lock_q  <= 1'b0;
      ov_en_q <= 1'b0;
      meas_q  <= 1'b0;
      pull_q  <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        test_q  <= avs_writedata[`CTRL_TEST_BIT];
        lock_q  <= avs_writedata[`CTRL_LOCK_BIT];
        ov_en_q <= avs_writedata[`CTRL_OV_RST_BIT];
        pull_q  <= avs_writedata[`CTRL_PULL_LSB+1:`CTRL_PULL_LSB];
        if (!lock_q && !meas_q)
          func_q <= avs_writedata[`CTRL_FUNC_LSB+2:`CTRL_FUNC_LSB];
        if (!is_fail || !avs_writedata[`CTRL_MEAS_BIT])
          meas_q <= avs_writedata[`CTRL_MEAS_BIT];
      end
      // low-side switched off on overcurrent or restart / fail-safe entry
      if (oc_trip || (is_ls && (enter_rst || enter_fs)))
        func_q <= `FUNC_OFF;
      // test-only activation is dropped when restart begins
      if (enter_rst)
        test_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog strike count and miss flag
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wd_miss_q <= 1'b0;
      strikes_q <= 2'h0;
    end else begin
      if (wd_trigger_fail) begin
        wd_miss_q <= 1'b1;
        if (strikes_q != 2'h3)
          strikes_q <= strikes_q + 2'h1;
      end else if (wd_trigger_ok || enter_slp ||
                   (enter_fs && hard_fail) ||
                   (sys_mode == `MODE_STOP && wd_disabled)) begin
        wd_miss_q <= 1'b0;
        strikes_q <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // failure activation, failure flag and release
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fail_act_q <= 1'b0;
      failure_q  <= 1'b0;
      wd_cause_q <= 1'b0;
    end else begin
      if (hard_fail || wd_fire) begin
        fail_act_q <= 1'b1;
        failure_q  <= 1'b1;
        if (wd_fire)
          wd_cause_q <= 1'b1;
      end else begin
        if (wr_dev && avs_writedata[`STAT_FAILURE_BIT])
          failure_q <= 1'b0;
        // every failure level must be gone, overvoltage whatever its enable
        if (sys_mode == `MODE_NORMAL && !failure_q && !main_overvoltage &&
            !(wd_cause_q && wd_miss_q)) begin
          fail_act_q <= 1'b0;
          wd_cause_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake and overcurrent status flags, set wins over clear
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_flag_q <= 1'b0;
      oc_flag_q   <= 1'b0;
    end else begin
      if (wk_edge)
        wake_flag_q <= 1'b1;
      else if (enter_fs ||
               (wr_wake && avs_writedata[`WK_PIN_EVENT_BIT]))
        wake_flag_q <= 1'b0;
      if (oc_trip)
        oc_flag_q <= 1'b1;
      else if (wr_wake && avs_writedata[`WK_PIN_OC_BIT])
        oc_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin driver, fail-safe request and wake request
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fail_signal_pin_out <= 1'b0;
      fail_signal_pin_oe  <= 1'b0;
      failsafe_req        <= 1'b0;
      wake_req            <= 1'b0;
    end else begin
      fail_signal_pin_out <= 1'b0;
      if (is_fail)
        fail_signal_pin_oe <= fail_act_q | test_q;
      else if (is_ls)
        fail_signal_pin_oe <= pwm_on & ~oc_trip;
      else
        fail_signal_pin_oe <= 1'b0;
      failsafe_req <= is_fail & (hard_fail | (wd_fire & two_strike_q));
      wake_req     <= wk_edge & (sys_mode == `MODE_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // irq pulse: low for the pulse time, then a minimum high gap
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_state_q <= IRQ_IDLE;
      irq_cnt_q   <= 12'h000;
      irq_pend_q  <= 1'b0;
      irq_line_n  <= 1'b1;
    end else begin
      if (wk_edge && (sys_mode == `MODE_NORMAL || sys_mode == `MODE_STOP))
        irq_pend_q <= 1'b1;
      case (irq_state_q)
        IRQ_IDLE: begin
          if (irq_pend_q) begin
            irq_pend_q  <= 1'b0;
            irq_line_n  <= 1'b0;
            irq_cnt_q   <= 12'h000;
            irq_state_q <= IRQ_PULSE;
          end
        end
        IRQ_PULSE: begin
          if (irq_cnt_q == IRQ_PULSE_CYC[11:0] - 12'h001) begin
            irq_line_n  <= 1'b1;
            irq_cnt_q   <= 12'h000;
            irq_state_q <= IRQ_GAP;
          end else begin
            irq_cnt_q <= irq_cnt_q + 12'h001;
          end
        end
        IRQ_GAP: begin
          if (irq_cnt_q == IRQ_GAP_CYC[11:0] - 12'h001)
            irq_state_q <= IRQ_IDLE;
          else
            irq_cnt_q <= irq_cnt_q + 12'h001;
        end
        default: begin
          irq_state_q <= IRQ_IDLE;
          irq_line_n  <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle, then data and waitrequest low together
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~bus_go;
      if (bus_go && avs_read) begin
        case (avs_address)
          `OFS_PIN_CTRL:
            avs_readdata <= {23'h000000, pull_q, meas_q, ov_en_q, lock_q,
                             test_q, func_q};
          `OFS_DEV_STATUS:
            avs_readdata <= {28'h0000000, wd_cause_q, two_strike_q,
                             wd_miss_q, failure_q};
          `OFS_WAKE_STATUS:
            avs_readdata <= {30'h00000000, oc_flag_q, wake_flag_q};
          `OFS_LEVEL_STATUS:
            avs_readdata <= {31'h00000000, wk_level};
          default:
            avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // fail_output_and_gpio_control

// ===== testbench/fo_gpio_checker.sv
// Purpose: concurrent checks on the fail output and gpio block ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   the high run-length counter saturates so long idle spans stay legal
`timescale 1ns/1ns
`include "fo_gpio_defs.vh"
module fo_gpio_checker #(
  parameter IRQ_PULSE_CYC = 10,
  parameter IRQ_GAP_CYC   = 10
) (
  input wire       clk,
  input wire       arst_n,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire [2:0] sys_mode,
  input wire       thermal_shutdown_level_two,
  input wire       main_short_to_gnd,
  input wire       main_overvoltage,
  input wire       wd_trigger_fail,
  input wire       fail_signal_pin_out,
  input wire       irq_line_n,
  input wire       failsafe_req,
  input wire       wake_req
);
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic [3:0]  since_q;
  logic        cause;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////////
  // any failure input that may justify a fail-safe request
  assign cause = thermal_shutdown_level_two | main_short_to_gnd | main_overvoltage |
                 wd_trigger_fail;
  // irq low and high run lengths, cycles since the last failure cause
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_q    <= 16'h0;
      hi_q    <= 16'hffff;
      since_q <= 4'hf;
    end else begin
      lo_q    <= irq_line_n ? 16'h0 : lo_q + 16'h1;
      hi_q    <= !irq_line_n ? 16'h0 : ((hi_q == 16'hffff) ? hi_q : hi_q + 16'h1);
      since_q <= cause ? 4'h0 : ((since_q == 4'hf) ? since_q : since_q + 4'h1);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // request taken, then exactly one answer cycle
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer missing or longer than one cycle");
  chk_pin_open_drain: assert property (!fail_signal_pin_out)
    else $error("pin output level driven high");
  chk_irq_width: assert property ($rose(irq_line_n) |-> lo_q == IRQ_PULSE_CYC)
    else $error("irq pulse width wrong");
  chk_irq_gap: assert property ($fell(irq_line_n) |-> hi_q >= IRQ_GAP_CYC)
    else $error("irq high time between pulses too short");
  chk_irq_mode: assert property ($fell(irq_line_n) |-> $past(sys_mode) inside {`MODE_NORMAL, `MODE_STOP})
    else $error("irq pulsed outside normal or stop mode");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  chk_wake_mode: assert property (wake_req |-> $past(sys_mode) == `MODE_SLEEP)
    else $error("wake request outside sleep mode");
  chk_failsafe_cause: assert property ($rose(failsafe_req) |-> since_q <= 4'h4)
    else $error("fail-safe request without a recent failure");
endmodule // fo_gpio_checker

bind fail_output_and_gpio_control fo_gpio_checker #(
  .IRQ_PULSE_CYC(IRQ_PULSE_CYC),
  .IRQ_GAP_CYC(IRQ_GAP_CYC)
) fo_gpio_checker_inst (.clk, .arst_n, .avs_read, .avs_write, .avs_waitrequest, .sys_mode,
  .thermal_shutdown_level_two, .main_short_to_gnd, .main_overvoltage, .wd_trigger_fail,
  .fail_signal_pin_out, .irq_line_n, .failsafe_req, .wake_req);

// ===== testbench/ext_pin_model.sv
// Purpose: board circuitry on the shared pin and on the irq pin
// Assumes: pull-up on the open-drain pin, strap resistor on irq
// Notes:   ext_low models an outside switch pulling the pin low
`timescale 1ns/1ns
module ext_pin_model (
  input  wire oe,
  input  wire ext_low,
  input  wire irq_n,
  input  wire strap_hi,
  output wire pin_level,
  output wire irq_level
);
  // pull-up wins unless either party pulls low
  assign pin_level = !(oe | ext_low);
  // strap sets the sensed level while irq is released high
  assign irq_level = irq_n & strap_hi;
endmodule // ext_pin_model

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the fail output and gpio pin control
// Assumes: shortened wake and irq timings, external pull-up on the pin
// Notes:   inputs change right after a rising edge, bus answers taken at the rising edge,
//          other outputs read at the falling edge
`timescale 1ns/1ns
`include "fo_gpio_defs.vh"
module tb_top;
  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [2:0]  sys_mode;
  logic        thermal_shutdown_level_two, main_short_to_gnd, main_overvoltage;
  logic        wd_trigger_fail, wd_trigger_ok, pwm_on, pin_overcurrent, wd_disabled;
  logic        fail_signal_pin_in, irq_line_in, fail_signal_pin_out, fail_signal_pin_oe;
  logic        irq_line_n, failsafe_req, wake_req, ext_low, strap_hi;
  int          fail_count, compares, n;
  //////////////////////////////////////////////////////////////////////////////
  fail_output_and_gpio_control #(.IRQ_PULSE_CYC(10), .IRQ_GAP_CYC(10), .WAKE_FILT_CYC(8),
    .WAKE_BLNK_CYC(4)) fail_output_and_gpio_control_inst (.clk, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sys_mode,
    .thermal_shutdown_level_two, .main_short_to_gnd, .main_overvoltage, .wd_trigger_fail,
    .wd_trigger_ok, .wd_disabled, .pwm_on, .pin_overcurrent, .fail_signal_pin_in,
    .irq_line_in, .fail_signal_pin_out, .fail_signal_pin_oe, .irq_line_n, .failsafe_req,
    .wake_req);
  ext_pin_model ext_pin_model_inst (.oe(fail_signal_pin_oe), .ext_low(ext_low),
    .irq_n(irq_line_n), .strap_hi(strap_hi), .pin_level(fail_signal_pin_in),
    .irq_level(irq_line_in));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task cb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    if (k >= 20) fail_count++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  task setm(input logic [2:0] m);
    @(posedge clk);
    sys_mode <= m;
  endtask
  task wdp(input logic ok);
    @(posedge clk);
    wd_trigger_ok   <= ok;
    wd_trigger_fail <= !ok;
    @(posedge clk);
    wd_trigger_ok   <= 1'b0;
    wd_trigger_fail <= 1'b0;
  endtask
  // wait for irq low or a wake request, counting cycles
  task evt(input logic w, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((w ? wake_req : !irq_line_n) !== 1'b1 && c < 100);
  endtask
  task rst(input logic s);
    @(posedge clk);
    arst_n   <= 1'b0;
    sys_mode <= `MODE_INIT;
    strap_hi <= s;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    sys_mode <= `MODE_NORMAL;
    wt(4);
  endtask
  task end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  // test sequence
  initial begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata, sys_mode} = '0;
    {thermal_shutdown_level_two, main_short_to_gnd, main_overvoltage} = 3'h0;
    {wd_trigger_fail, wd_trigger_ok, pwm_on, pin_overcurrent, strap_hi, wd_disabled} = 6'h0;
    {fail_count, compares} = '0;
    ext_low = 1'b1;
    rst(1'b0);
    rd(4'h0, 32'hffffffff, 32'h0);
    rd(4'h2, 32'hffffffff, 32'h0);
    cb(fail_signal_pin_oe, 1'b0);
    wr(4'h0, 32'h8);
    wt(3);
    cb(fail_signal_pin_oe, 1'b1);
    wr(4'h0, 32'h0);
    wt(3);
    cb(fail_signal_pin_oe, 1'b0);
    wr(4'h0, 32'hc);
    wt(3);
    cb(fail_signal_pin_oe, 1'b0);
    rd(4'h0, 32'h1ff, 32'hc);
    wr(4'h0, 32'h8);
    setm(`MODE_RESTART);
    wt(3);
    cb(fail_signal_pin_oe, 1'b0);
    setm(`MODE_NORMAL);
    wt(3);
    cb(fail_signal_pin_oe, 1'b0);
    $display("test 1 done");
    wr(4'h0, 32'h20);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {main_overvoltage, main_short_to_gnd, thermal_shutdown_level_two} <= 3'h1 << i;
      wt(4);
      cb(fail_signal_pin_oe, 1'b1);
      cb(failsafe_req, 1'b1);
      rd(4'h4, 32'h1, 32'h1);
      setm(`MODE_STOP);
      wt(2);
      cb(fail_signal_pin_oe, 1'b1);
      setm(`MODE_NORMAL);
      wr(4'h4, 32'h1);
      rd(4'h4, 32'h1, 32'h1);
      @(posedge clk);
      {main_overvoltage, main_short_to_gnd, thermal_shutdown_level_two} <= 3'h0;
      wt(2);
      cb(fail_signal_pin_oe, 1'b1);
      wr(4'h4, 32'h1);
      wt(2);
      cb(fail_signal_pin_oe, 1'b0);
    end
    wr(4'h0, 32'h0);
    @(posedge clk);
    main_overvoltage <= 1'b1;
    wt(4);
    cb(fail_signal_pin_oe, 1'b0);
    @(posedge clk);
    main_overvoltage <= 1'b0;
    $display("test 2 done");
    wdp(1'b0);
    @(negedge clk);
    cb(failsafe_req, 1'b0);
    wt(4);
    cb(fail_signal_pin_oe, 1'b1);
    rd(4'h4, 32'hf, 32'hb);
    wr(4'h4, 32'h1);
    wt(2);
    cb(fail_signal_pin_oe, 1'b1);
    wdp(1'b1);
    wt(4);
    cb(fail_signal_pin_oe, 1'b0);
    rd(4'h4, 32'h3, 32'h0);
    rst(1'b1);
    rd(4'h4, 32'h4, 32'h4);
    wdp(1'b0);
    wt(4);
    cb(fail_signal_pin_oe, 1'b0);
    rd(4'h4, 32'h2, 32'h2);
    @(posedge clk);
    sys_mode    <= `MODE_STOP;
    wd_disabled <= 1'b1;
    wt(2);
    rd(4'h4, 32'h2, 32'h0);
    @(posedge clk);
    sys_mode    <= `MODE_NORMAL;
    wd_disabled <= 1'b0;
    wdp(1'b0);
    wt(4);
    cb(fail_signal_pin_oe, 1'b0);
    wdp(1'b0);
    @(negedge clk);
    cb(failsafe_req, 1'b1);
    wt(4);
    cb(fail_signal_pin_oe, 1'b1);
    setm(`MODE_SLEEP);
    wt(3);
    setm(`MODE_NORMAL);
    rd(4'h4, 32'h2, 32'h0);
    wr(4'h4, 32'h1);
    wt(3);
    cb(fail_signal_pin_oe, 1'b0);
    $display("test 3 done");
    wr(4'h0, 32'h14);
    @(posedge clk);
    thermal_shutdown_level_two <= 1'b1;
    wt(4);
    cb(fail_signal_pin_oe, 1'b0);
    @(posedge clk);
    thermal_shutdown_level_two <= 1'b0;
    wr(4'h4, 32'h1);
    wr(4'h0, 32'h10);
    rd(4'h0, 32'h17, 32'h14);
    wr(4'h0, 32'h0);
    rd(4'h0, 32'h17, 32'h4);
    wr(4'h0, 32'h44);
    wr(4'h0, 32'h0);
    rd(4'h0, 32'h47, 32'h4);
    $display("test 4 done");
    wr(4'h0, 32'h5);
    @(posedge clk);
    ext_low <= 1'b0;
    evt(1'b0, n);
    cb(n >= 11 && n < 40, 1'b1);
    rd(4'h8, 32'h1, 32'h1);
    rd(4'hc, 32'h1, 32'h1);
    wr(4'h8, 32'h1);
    wt(30);
    setm(`MODE_SLEEP);
    wt(2);
    @(posedge clk);
    ext_low <= 1'b1;
    evt(1'b1, n);
    cb(wake_req, 1'b1);
    wt(30);
    setm(`MODE_NORMAL);
    wr(4'h8, 32'h1);
    setm(`MODE_RESTART);
    @(posedge clk);
    ext_low <= 1'b0;
    wt(30);
    setm(`MODE_NORMAL);
    rd(4'h8, 32'h1, 32'h1);
    setm(`MODE_FAILSAFE);
    wt(3);
    setm(`MODE_NORMAL);
    rd(4'h8, 32'h1, 32'h0);
    wr(4'h0, 32'hd);
    wt(3);
    cb(fail_signal_pin_oe, 1'b0);
    $display("test 5 done");
    wr(4'h0, 32'h6);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pwm_on <= i[0];
      wt(3);
      cb(fail_signal_pin_oe, i[0]);
    end
    @(posedge clk);
    pin_overcurrent <= 1'b1;
    wt(4);
    cb(fail_signal_pin_oe, 1'b0);
    rd(4'h8, 32'h2, 32'h2);
    rd(4'h0, 32'h7, 32'h4);
    $display("test 6 done");
    end_sim;
  end
endmodule // tb_top
